// *** logic/eth_path_pkg.sv ***
// shared constants, register map and state types for the path control block
package eth_path_pkg;

  // lane and data geometry
  localparam int LANE_COUNT = 20;
  localparam int ERR_CNT_W  = 4;
  localparam int DATA_W     = 64;

  // register byte offsets
  localparam logic [7:0] REG_CTRL       = 8'h00;
  localparam logic [7:0] REG_STATUS     = 8'h04;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK   = 8'h0c;

  // control register fields
  localparam int CTRL_W          = 4;
  localparam int CTRL_TX_EN_BIT  = 0;
  localparam int CTRL_TX_RF_BIT  = 1;
  localparam int CTRL_TX_IDL_BIT = 2;
  localparam int CTRL_RX_EN_BIT  = 3;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 4'ha;

  // status register fields
  localparam int STAT_LF_BIT     = 0;
  localparam int STAT_TX_PKT_BIT = 1;
  localparam int STAT_RX_OFF_BIT = 2;
  localparam int STAT_RX_PKT_BIT = 3;
  localparam int STAT_DEC_RUN_BIT = 4;

  // interrupt status and mask fields
  localparam int IRQ_W            = 5;
  localparam int IRQ_LF_SET_BIT   = 0;
  localparam int IRQ_LF_CLR_BIT   = 1;
  localparam int IRQ_TX_ERR_BIT   = 2;
  localparam int IRQ_LANE_ERR_BIT = 3;
  localparam int IRQ_REALIGN_BIT  = 4;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 5'h00;

  // cycle counts
  localparam logic [7:0] ALIGN_CYCLES = 8'h40;
  localparam logic [3:0] REPORT_LAST  = 4'hf;

  // link code words
  localparam logic [DATA_W-1:0] IDLE_WORD  = 64'h0707070707070707;
  localparam logic [DATA_W-1:0] FAULT_WORD = 64'h0200000002000000;
  localparam logic [DATA_W-1:0] ERROR_WORD = 64'hfefefefefefefefe;

  typedef enum logic [1:0] {WORD_IDLE, WORD_FAULT, WORD_DATA, WORD_ERROR} tx_word_kind_t;
  typedef enum logic {TX_WAIT, TX_SEND} tx_state_t;
  typedef enum logic {DEC_INIT, DEC_RUN} dec_state_t;
  typedef enum logic [1:0] {RX_OFF, RX_READY, RX_PACKET} rx_state_t;

endpackage : eth_path_pkg

// *** logic/tx_word_out.sv ***
// registered transmit link word selector
`timescale 1ns/1ps
module tx_word_out
  import eth_path_pkg::*;
#(
  parameter int DW = DATA_W
)
(
  // clock and reset
  input  wire logic          core_clk,
  input  wire logic          resetn,
  // selection
  input  tx_word_kind_t      word_kind,
  input  wire logic [DW-1:0] word_data,
  // link side
  output logic      [DW-1:0] link_data,
  output logic               link_ctrl,
  output logic               fcs_suppress
);

  typedef struct packed {
    logic [DW-1:0] data;
    logic          ctrl;
    logic          fcs_off;
  } out_state_t;

  out_state_t q;
  out_state_t d;

  // pick code word or payload
  always_comb
  begin
    d = q;
    d.fcs_off = 1'b0;
    case (word_kind)
      WORD_DATA:
      begin
        d.data = word_data;
        d.ctrl = 1'b0;
      end
      WORD_ERROR:
      begin
        d.data    = ERROR_WORD[DW-1:0];
        d.ctrl    = 1'b1;
        d.fcs_off = 1'b1;
      end
      WORD_FAULT:
      begin
        d.data = FAULT_WORD[DW-1:0];
        d.ctrl = 1'b1;
      end
      default:
      begin
        d.data = IDLE_WORD[DW-1:0];
        d.ctrl = 1'b1;
      end
    endcase
  end

  // state register
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      q <= '{data: IDLE_WORD[DW-1:0], ctrl: 1'b1, fcs_off: 1'b0};
    else
      q <= d;
  end

  assign link_data    = q.data;
  assign link_ctrl    = q.ctrl;
  assign fcs_suppress = q.fcs_off;

endmodule : tx_word_out

// *** logic/lane_err_accum.sv ***
// per-lane sync header error accumulators with periodic increment reports
`timescale 1ns/1ps
module lane_err_accum
  import eth_path_pkg::*;
#(
  parameter int LANES = LANE_COUNT,
  parameter int CW    = ERR_CNT_W
)
(
  // clock and reset
  input  wire logic                core_clk,
  input  wire logic                resetn,
  // error events
  input  wire logic [LANES-1:0]    hdr_err,
  input  wire logic                count_en,
  input  wire logic                report_tick,
  // reports
  output logic      [LANES*CW-1:0] err_count,
  output logic      [LANES-1:0]    err_valid,
  output logic                     any_report
);

  typedef struct packed {
    logic [LANES-1:0][CW-1:0] acc;
    logic [LANES-1:0][CW-1:0] cnt;
    logic [LANES-1:0]         vld;
    logic                     any;
  } acc_state_t;

  acc_state_t q;
  acc_state_t d;

  // saturating add of one error
  function automatic logic [CW-1:0] sat_inc(input logic [CW-1:0] v, input logic inc);
    if (inc && (v != {CW{1'b1}}))
      sat_inc = v + {{(CW-1){1'b0}}, 1'b1};
    else
      sat_inc = v;
  endfunction : sat_inc

  // accumulate, then hand out the sum as one increment
  always_comb
  begin
    d = q;
    d.any = 1'b0;
    for (int i = 0; i < LANES; i++)
    begin
      d.vld[i] = 1'b0;
      if (report_tick && count_en)
      begin
        d.cnt[i] = q.acc[i];
        d.vld[i] = (q.acc[i] != '0);
        d.acc[i] = {{(CW-1){1'b0}}, hdr_err[i]};
        if (q.acc[i] != '0)
          d.any = 1'b1;
      end
      else
        d.acc[i] = sat_inc(q.acc[i], count_en & hdr_err[i]);
    end
  end

  // state register
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      q <= '0;
    else
      q <= d;
  end

  assign err_count  = q.cnt;
  assign err_valid  = q.vld;
  assign any_report = q.any;

endmodule : lane_err_accum

// *** logic/eth_path_control_status.sv ***
// transmit and receive path control and status with wishbone registers
// What this block does
// - transmit disabled: idles (fault words if remote fault set), no packet start
// - disable mid-packet finishes packet, then stops
// - send remote fault: fault words only
// - force idle: idle words only, unless send remote fault is also set
// - local fault high exactly in decoder init
// - receive disable finishes packet, stops decoding
// - receive disabled: no statistics, user bus idle
// - realign high resets receive path, realigns
// - four-bit sync header error count per lane
// - lane count meaningful only with valid
// - counts are increments, updated once every 16 cycles
// - error on last word sends error code
//
// The register addresses and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module eth_path_control_status
  import eth_path_pkg::*;
#(
  parameter int LANES = LANE_COUNT,
  parameter int DW    = DATA_W
)
(
  // clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       resetn,
  // wishbone slave
  input  wire logic                       wb_cyc_i,
  input  wire logic                       wb_stb_i,
  input  wire logic                       wb_we_i,
  input  wire logic [7:0]                 wb_adr_i,
  input  wire logic [3:0]                 wb_sel_i,
  input  wire logic [31:0]                wb_dat_i,
  output logic      [31:0]                wb_dat_o,
  output logic                            wb_ack_o,
  // interrupt
  output logic                            irq,
  // transmit user packet bus
  input  wire logic                       tx_pkt_valid,
  input  wire logic                       tx_pkt_sop,
  input  wire logic                       tx_pkt_eop,
  input  wire logic                       tx_packet_error_flag,
  input  wire logic [DW-1:0]              tx_pkt_data,
  output logic                            tx_pkt_ready,
  // transmit link
  output logic      [DW-1:0]              tx_link_data,
  output logic                            tx_link_ctrl,
  output logic                            tx_fcs_suppress,
  output logic                            stat_tx_local_fault,
  // receive link
  input  wire logic                       rx_force_realign,
  input  wire logic [LANES-1:0]           rx_lane_locked,
  input  wire logic [LANES-1:0]           rx_lane_hdr_err,
  input  wire logic                       rx_link_valid,
  input  wire logic                       rx_link_sop,
  input  wire logic                       rx_link_eop,
  input  wire logic [DW-1:0]              rx_link_data,
  // receive user packet bus
  output logic                            rx_user_valid,
  output logic                            rx_user_sop,
  output logic                            rx_user_eop,
  output logic      [DW-1:0]              rx_user_data,
  // lane framing error reports
  output logic      [LANES*ERR_CNT_W-1:0] rx_lane_err_count,
  output logic      [LANES-1:0]           rx_lane_err_valid
);

  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;
    logic [IRQ_W-1:0]  irq_stat;
    logic [IRQ_W-1:0]  irq_mask;
    logic              ack;
    logic [31:0]       rdata;
    logic              irq;
    logic              sync1;
    logic              sync2;
    logic              sync3;
    dec_state_t        dec;
    logic [7:0]        align_cnt;
    logic              local_fault;
    tx_state_t         tx_state;
    logic              tx_ready;
    rx_state_t         rx_state;
    logic              rx_valid;
    logic              rx_sop;
    logic              rx_eop;
    logic [DW-1:0]     rx_data;
    logic [3:0]        tick_cnt;
    logic              tick;
  } main_state_t;

  main_state_t q;
  main_state_t d;

  // wires to and from the submodules, and internal strobes for bus, interrupts and handshakes
  tx_word_kind_t  word_kind;
  logic           lane_report;
  logic           stats_en;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;
  logic           wr_en;
  logic           rd_en;
  logic           tx_xfer;
  logic           rx_take;

  // merge sel-gated low byte into a register value
  function automatic logic [7:0] merge_byte(input logic [7:0] old_v, input logic [7:0] new_v,
                                            input logic sel);
    merge_byte = sel ? new_v : old_v;
  endfunction : merge_byte

  // lock lost on any lane or realign request seen
  function automatic logic align_lost(input logic req, input logic [LANES-1:0] locked);
    align_lost = req | ~(&locked);
  endfunction : align_lost

  // whole next-state function
  always_comb
  begin
    d           = q;
    word_kind   = WORD_IDLE;
    irq_set     = '0;
    irq_clr     = '0;
    stats_en    = 1'b0;
    tx_xfer     = tx_pkt_valid & q.tx_ready;
    rx_take     = 1'b0;

    // bus slave: one wait state, ack drops after one cycle
    // read data held at zero outside ack, no stale word on the bus
    wr_en = wb_cyc_i & wb_stb_i & ~q.ack & wb_we_i;
    rd_en = wb_cyc_i & wb_stb_i & ~q.ack & ~wb_we_i;
    d.ack = wb_cyc_i & wb_stb_i & ~q.ack;
    if (wr_en)
    begin
      case (wb_adr_i)
        REG_CTRL:
          d.ctrl = CTRL_W'(merge_byte(8'(q.ctrl), wb_dat_i[7:0], wb_sel_i[0]));
        REG_IRQ_MASK:
          d.irq_mask = IRQ_W'(merge_byte(8'(q.irq_mask), wb_dat_i[7:0], wb_sel_i[0]));
        REG_IRQ_STATUS:
          irq_clr = wb_sel_i[0] ? wb_dat_i[IRQ_W-1:0] : '0;
        default:
          d.ctrl = q.ctrl;
      endcase
    end
    if (rd_en)
    begin
      case (wb_adr_i)
        REG_CTRL:       d.rdata = 32'(q.ctrl);
        REG_STATUS:
        begin
          d.rdata = 32'h0;
          d.rdata[STAT_LF_BIT]      = q.local_fault;
          d.rdata[STAT_TX_PKT_BIT]  = (q.tx_state == TX_SEND);
          d.rdata[STAT_RX_OFF_BIT]  = (q.rx_state == RX_OFF);
          d.rdata[STAT_RX_PKT_BIT]  = (q.rx_state == RX_PACKET);
          d.rdata[STAT_DEC_RUN_BIT] = (q.dec == DEC_RUN);
        end
        REG_IRQ_STATUS: d.rdata = 32'(q.irq_stat);
        REG_IRQ_MASK:   d.rdata = 32'(q.irq_mask);
        default:        d.rdata = 32'h0;
      endcase
    end
    else if (!d.ack)
      d.rdata = 32'h0;

    // an override drops a packet in flight; user must resend it
    // transmit path, fault and idle override everything
    if (q.ctrl[CTRL_TX_RF_BIT])
    begin
      word_kind  = WORD_FAULT;
      d.tx_state = TX_WAIT;
    end
    else if (q.ctrl[CTRL_TX_IDL_BIT])
    begin
      word_kind  = WORD_IDLE;
      d.tx_state = TX_WAIT;
    end
    else if (tx_xfer && (q.tx_state == TX_SEND || tx_pkt_sop))
    begin
      if (tx_pkt_eop && tx_packet_error_flag)
      begin
        word_kind = WORD_ERROR;
        irq_set[IRQ_TX_ERR_BIT] = 1'b1;
      end
      else
        word_kind = WORD_DATA;
      d.tx_state = tx_pkt_eop ? TX_WAIT : TX_SEND;
    end
    // a new packet may start only while enabled
    d.tx_ready = ~d.ctrl[CTRL_TX_RF_BIT] & ~d.ctrl[CTRL_TX_IDL_BIT] &
                 ((d.tx_state == TX_SEND) | d.ctrl[CTRL_TX_EN_BIT]);

    // realign input through two flops, third for edge
    d.sync1 = rx_force_realign;
    d.sync2 = q.sync1;
    d.sync3 = q.sync2;
    if (q.sync2 && !q.sync3)
      irq_set[IRQ_REALIGN_BIT] = 1'b1;

    // decoder alignment state machine
    // fault clears after ALIGN_CYCLES plus one cycles of lock
    case (q.dec)
      DEC_INIT:
      begin
        if (align_lost(q.sync2, rx_lane_locked))
          d.align_cnt = 8'h00;
        else if (q.align_cnt == ALIGN_CYCLES)
          d.dec = DEC_RUN;
        else
          d.align_cnt = q.align_cnt + 8'h01;
      end
      DEC_RUN:
      begin
        if (align_lost(q.sync2, rx_lane_locked))
        begin
          d.dec       = DEC_INIT;
          d.align_cnt = 8'h00;
        end
      end
      default:
        d.dec = DEC_INIT;
    endcase
    d.local_fault = (d.dec == DEC_INIT);
    if (d.local_fault && !q.local_fault)
      irq_set[IRQ_LF_SET_BIT] = 1'b1;
    if (!d.local_fault && q.local_fault)
      irq_set[IRQ_LF_CLR_BIT] = 1'b1;

    // leaving run state drops the packet in flight
    // receive packet gating
    d.rx_valid = 1'b0;
    d.rx_sop   = 1'b0;
    d.rx_eop   = 1'b0;
    if (q.dec != DEC_RUN || d.dec != DEC_RUN)
      d.rx_state = q.ctrl[CTRL_RX_EN_BIT] ? RX_READY : RX_OFF;
    else
    begin
      case (q.rx_state)
        RX_OFF:
          if (q.ctrl[CTRL_RX_EN_BIT])
            d.rx_state = RX_READY;
        RX_READY:
        begin
          if (!q.ctrl[CTRL_RX_EN_BIT])
            d.rx_state = RX_OFF;
          else if (rx_link_valid && rx_link_sop)
          begin
            rx_take    = 1'b1;
            d.rx_state = rx_link_eop ? RX_READY : RX_PACKET;
          end
        end
        RX_PACKET:
        begin
          if (rx_link_valid)
          begin
            rx_take = 1'b1;
            if (rx_link_eop)
              d.rx_state = q.ctrl[CTRL_RX_EN_BIT] ? RX_READY : RX_OFF;
          end
        end
        default:
          d.rx_state = RX_OFF;
      endcase
    end
    if (rx_take)
    begin
      d.rx_valid = 1'b1;
      d.rx_sop   = rx_link_sop;
      d.rx_eop   = rx_link_eop;
      d.rx_data  = rx_link_data;
    end
    stats_en = (q.dec == DEC_RUN) && (q.rx_state != RX_OFF);

    // report divider
    d.tick     = (q.tick_cnt == REPORT_LAST);
    d.tick_cnt = d.tick ? 4'h0 : q.tick_cnt + 4'h1;

    // interrupts: set wins over write-one clear
    if (lane_report)
      irq_set[IRQ_LANE_ERR_BIT] = 1'b1;
    d.irq_stat = (q.irq_stat & ~irq_clr) | irq_set;
    d.irq      = |(d.irq_stat & d.irq_mask);
  end

  // state register
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      q             <= '0;
      q.ctrl        <= CTRL_RESET;
      q.irq_mask    <= IRQ_MASK_RESET;
      q.dec         <= DEC_INIT;
      q.local_fault <= 1'b1;
      q.tx_state    <= TX_WAIT;
      q.rx_state    <= RX_OFF;
    end
    else
      q <= d;
  end

  // transmit word register
  tx_word_out #(
    .DW (DW)
  ) u_tx_word (
    .core_clk     (core_clk),
    .resetn       (resetn),
    .word_kind    (word_kind),
    .word_data    (tx_pkt_data),
    .link_data    (tx_link_data),
    .link_ctrl    (tx_link_ctrl),
    .fcs_suppress (tx_fcs_suppress)
  );

  // lane error accumulators
  lane_err_accum #(
    .LANES (LANES),
    .CW    (ERR_CNT_W)
  ) u_lane_err (
    .core_clk    (core_clk),
    .resetn      (resetn),
    .hdr_err     (rx_lane_hdr_err),
    .count_en    (stats_en),
    .report_tick (q.tick),
    .err_count   (rx_lane_err_count),
    .err_valid   (rx_lane_err_valid),
    .any_report  (lane_report)
  );

  // flop-driven outputs
  assign wb_dat_o            = q.rdata;
  assign wb_ack_o            = q.ack;
  assign irq                 = q.irq;
  assign tx_pkt_ready        = q.tx_ready;
  assign stat_tx_local_fault = q.local_fault;
  assign rx_user_valid       = q.rx_valid;
  assign rx_user_sop         = q.rx_sop;
  assign rx_user_eop         = q.rx_eop;
  assign rx_user_data        = q.rx_data;

endmodule : eth_path_control_status

// *** testbench/eth_path_properties.sv ***
// assertion checker for the path control block
`timescale 1ns/1ps
module eth_path_checker
  import eth_path_pkg::*;
#(
  parameter int LANES = LANE_COUNT,
  parameter int DW    = DATA_W
)
(
  // clock and reset
  input wire logic             core_clk,
  input wire logic             resetn,
  // register bus
  input wire logic             wb_cyc_i,
  input wire logic             wb_stb_i,
  input wire logic             wb_ack_o,
  // transmit
  input wire logic             tx_pkt_valid,
  input wire logic             tx_pkt_ready,
  input wire logic             tx_pkt_sop,
  input wire logic             tx_pkt_eop,
  input wire logic             tx_packet_error_flag,
  input wire logic [DW-1:0]    tx_pkt_data,
  input wire logic [DW-1:0]    tx_link_data,
  input wire logic             tx_link_ctrl,
  input wire logic             tx_fcs_suppress,
  input wire logic             stat_tx_local_fault,
  // receive
  input wire logic             rx_force_realign,
  input wire logic [LANES-1:0] rx_lane_locked,
  input wire logic             rx_link_valid,
  input wire logic [DW-1:0]    rx_link_data,
  input wire logic             rx_user_valid,
  input wire logic [DW-1:0]    rx_user_data
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  logic [7:0] lock_cnt_q;
  // cycles of unbroken lock with no realign request
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      lock_cnt_q <= 8'h00;
    else if (!(&rx_lane_locked) || rx_force_realign)
      lock_cnt_q <= 8'h00;
    else if (lock_cnt_q != 8'hff)
      lock_cnt_q <= lock_cnt_q + 8'h01;
  end
  // bus answer
  a_ack_next_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  // transmit path
  a_sop_word_sent: assert property (tx_pkt_valid && tx_pkt_ready && tx_pkt_sop && !tx_pkt_eop |=>
    !tx_link_ctrl && tx_link_data == $past(tx_pkt_data)) else $error("taken start word not sent");
  a_err_code_sent: assert property (tx_pkt_valid && tx_pkt_ready && tx_pkt_sop && tx_pkt_eop
    && tx_packet_error_flag |=> tx_fcs_suppress) else $error("error packet not marked");
  a_fcs_with_code: assert property (tx_fcs_suppress |-> tx_link_ctrl && tx_link_data == ERROR_WORD)
    else $error("fcs suppress without error code");
  // receive path
  a_unlock_fault: assert property (!(&rx_lane_locked) |-> ##[1:2] stat_tx_local_fault)
    else $error("local fault low after lock loss");
  a_realign_fault: assert property ($rose(rx_force_realign) |-> ##[1:4] stat_tx_local_fault)
    else $error("realign did not reset receive path");
  a_fault_hold_time: assert property ($fell(stat_tx_local_fault) |-> lock_cnt_q >= ALIGN_CYCLES)
    else $error("local fault cleared too early");
  a_rx_user_follow: assert property (rx_user_valid |-> $past(rx_link_valid)
    && rx_user_data == $past(rx_link_data)) else $error("user word not from link");
endmodule : eth_path_checker

bind eth_path_control_status eth_path_checker #(.LANES(LANES), .DW(DW)) chk_i (.core_clk, .resetn,
  .wb_cyc_i, .wb_stb_i, .wb_ack_o, .tx_pkt_valid, .tx_pkt_ready, .tx_pkt_sop, .tx_pkt_eop,
  .tx_packet_error_flag, .tx_pkt_data, .tx_link_data, .tx_link_ctrl, .tx_fcs_suppress,
  .stat_tx_local_fault, .rx_force_realign, .rx_lane_locked, .rx_link_valid, .rx_link_data,
  .rx_user_valid, .rx_user_data);

// *** testbench/link_partner_model.sv ***
// remote link partner model driving the receive lanes
`timescale 1ns/1ps
module link_partner_model
  import eth_path_pkg::*;
(
  // clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  resetn,
  // bench commands
  input  wire logic                  lock_cmd,
  input  wire logic [LANE_COUNT-1:0] err_cmd,
  input  wire logic                  go,
  input  wire logic [7:0]            flen,
  input  wire logic [DATA_W-1:0]     fbase,
  // receive link toward the block
  output logic      [LANE_COUNT-1:0] rx_lane_locked,
  output logic      [LANE_COUNT-1:0] rx_lane_hdr_err,
  output logic                       rx_link_valid,
  output logic                       rx_link_sop,
  output logic                       rx_link_eop,
  output logic      [DATA_W-1:0]     rx_link_data
);
  logic [7:0] left_q;
  logic [7:0] pos_q;
  // frame sequencer; idle data toggles so stale words never look real
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      left_q          <= 8'h00;
      pos_q           <= 8'h00;
      rx_lane_locked  <= '0;
      rx_lane_hdr_err <= '0;
      rx_link_valid   <= 1'b0;
      rx_link_sop     <= 1'b0;
      rx_link_eop     <= 1'b0;
      rx_link_data    <= '0;
    end
    else
    begin
      rx_lane_locked  <= {LANE_COUNT{lock_cmd}};
      rx_lane_hdr_err <= err_cmd;
      rx_link_valid   <= (left_q != 8'h00);
      rx_link_sop     <= (left_q != 8'h00) && (pos_q == 8'h00);
      rx_link_eop     <= (left_q == 8'h01);
      rx_link_data    <= (left_q != 8'h00) ? fbase + DATA_W'(pos_q) : ~rx_link_data;
      if (left_q != 8'h00)
      begin
        left_q <= left_q - 8'h01;
        pos_q  <= pos_q + 8'h01;
      end
      else if (go)
      begin
        left_q <= flen;
        pos_q  <= 8'h00;
      end
    end
  end
endmodule : link_partner_model

// *** testbench/tb_eth_path_control_status.sv ***
// self-checking bench for the path control block
`timescale 1ns/1ps
module tb_eth_path_control_status
  import eth_path_pkg::*;
;
  logic        core_clk = 0, resetn = 0, irq, wb_ack_o;
  logic        wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [7:0]  wb_adr_i = '0, flen = '0;
  logic [3:0]  wb_sel_i = '0;
  logic [31:0] wb_dat_i = '0, wb_dat_o, r;
  logic        tx_pkt_valid = 0, tx_pkt_sop = 0, tx_pkt_eop = 0, tx_packet_error_flag = 0;
  logic        tx_pkt_ready, tx_link_ctrl, tx_fcs_suppress, stat_tx_local_fault;
  logic [63:0] tx_pkt_data = '0, tx_link_data, rx_link_data, rx_user_data, fbase = '0;
  logic        rx_force_realign = 0, lock_cmd = 0, go = 0;
  logic [19:0] rx_lane_locked, rx_lane_hdr_err, rx_lane_err_valid, err_cmd = '0;
  logic        rx_link_valid, rx_link_sop, rx_link_eop, rx_user_valid, rx_user_sop, rx_user_eop;
  logic [79:0] rx_lane_err_count;
  int          mismatches = 0, check_count = 0, fcs_n = 0, n, sop_n = 0, eop_n = 0;
  int          lane_sum[20] = '{default: 0};
  logic [63:0] txq[$], rxq[$];
  eth_path_control_status uut (.core_clk, .resetn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq, .tx_pkt_valid, .tx_pkt_sop, .tx_pkt_eop,
    .tx_packet_error_flag, .tx_pkt_data, .tx_pkt_ready, .tx_link_data, .tx_link_ctrl, .tx_fcs_suppress,
    .stat_tx_local_fault, .rx_force_realign, .rx_lane_locked, .rx_lane_hdr_err, .rx_link_valid,
    .rx_link_sop, .rx_link_eop, .rx_link_data, .rx_user_valid, .rx_user_sop, .rx_user_eop,
    .rx_user_data, .rx_lane_err_count, .rx_lane_err_valid);
  link_partner_model partner (.core_clk, .resetn, .lock_cmd, .err_cmd, .go, .flen, .fbase,
    .rx_lane_locked, .rx_lane_hdr_err, .rx_link_valid, .rx_link_sop, .rx_link_eop, .rx_link_data);
  // clock
  initial forever #12.5 core_clk = ~core_clk;
  // link monitors
  always @(posedge core_clk)
  begin
    if (tx_link_ctrl === 1'b0) txq.push_back(tx_link_data);
    if (tx_fcs_suppress === 1'b1) fcs_n++;
    if (rx_user_valid === 1'b1) rxq.push_back(rx_user_data);
    if (rx_user_valid === 1'b1 && rx_user_sop === 1'b1) sop_n++;
    if (rx_user_valid === 1'b1 && rx_user_eop === 1'b1) eop_n++;
    for (int i = 0; i < 20; i++)
      if (rx_lane_err_valid[i] === 1'b1) lane_sum[i] += rx_lane_err_count[4*i +: 4];
  end
  task chk(input logic [63:0] g, input logic [63:0] e);
    check_count++;
    if (g !== e)
    begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task end_sim;
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_sim
  task cyc(input int k);
    repeat (k) @(posedge core_clk);
  endtask : cyc
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    k = 0;
    do
    begin
      @(posedge core_clk);
      k++;
    end
    while (wb_ack_o !== 1'b1 && k < 20);
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (k >= 20) begin mismatches++; end_sim(); end
    @(posedge core_clk);
  endtask : wb
  task txw(input logic s, input logic e, input logic er, input logic [63:0] d);
    int k;
    @(posedge core_clk);
    tx_pkt_valid <= 1'b1;
    tx_pkt_sop <= s;
    tx_pkt_eop <= e;
    tx_packet_error_flag <= er;
    tx_pkt_data <= d;
    k = 0;
    do
    begin
      @(posedge core_clk);
      k++;
    end
    while (tx_pkt_ready !== 1'b1 && k < 20);
    tx_pkt_valid <= 1'b0;
    if (k >= 20) begin mismatches++; end_sim(); end
  endtask : txw
  task wait_lf(input logic v);
    n = 0;
    while (stat_tx_local_fault !== v && n < 200) begin @(posedge core_clk); n++; end
    if (n >= 200) begin mismatches++; end_sim(); end
  endtask : wait_lf
  task frame(input logic [7:0] k, input logic [63:0] b);
    @(posedge core_clk);
    go <= 1'b1;
    flen <= k;
    fbase <= b;
    @(posedge core_clk);
    go <= 1'b0;
    cyc(k + 4);
  endtask : frame
  // main sequence
  initial
  begin
    cyc(2);
    resetn <= 1'b1;
    wb(0, REG_CTRL, 0); chk(r, CTRL_RESET);
    wb(0, REG_IRQ_MASK, 0); chk(r, IRQ_MASK_RESET);
    wb(0, 8'h10, 0); chk(r, 0);
    chk(tx_link_data, FAULT_WORD);
    chk(stat_tx_local_fault, 1);
    $display("reset test done");
    lock_cmd <= 1'b1;
    wait_lf(0); chk(n >= 64, 1);
    wb(0, REG_STATUS, 0); chk(r[STAT_DEC_RUN_BIT], 1);
    wb(1, REG_IRQ_MASK, 32'h02); cyc(2); chk(irq, 1);
    wb(1, REG_IRQ_STATUS, 32'h02); cyc(2); chk(irq, 0);
    $display("align test done");
    wb(1, REG_CTRL, 32'h09); cyc(2); chk(tx_link_data, IDLE_WORD);
    txq.delete();
    txw(1, 0, 0, 64'h1111); txw(0, 1, 0, 64'h2222); cyc(3);
    chk(txq.size(), 2); chk(txq[0], 64'h1111); chk(txq[1], 64'h2222);
    n = fcs_n; txw(1, 1, 1, 64'h3333); cyc(3); chk(fcs_n - n, 1);
    txq.delete(); txw(1, 0, 0, 64'h4444); wb(1, REG_CTRL, 32'h08); chk(tx_pkt_ready, 1);
    txw(0, 1, 0, 64'h5555); cyc(3); chk(txq.size(), 2);
    chk(tx_pkt_ready, 0); chk(tx_link_data, IDLE_WORD);
    $display("transmit test done");
    wb(1, REG_CTRL, 32'h0d); cyc(2); chk(tx_pkt_ready, 0); chk(tx_link_data, IDLE_WORD);
    wb(1, REG_CTRL, 32'h0b); cyc(2); chk(tx_link_data, FAULT_WORD);
    $display("force test done");
    rxq.delete(); frame(4, 64'h100); chk(rxq.size(), 4); chk(rxq[3], 64'h103);
    chk(sop_n, 1);
    chk(eop_n, 1);
    fork
      frame(6, 64'h200);
      begin cyc(2); wb(1, REG_CTRL, 32'h01); end
    join
    chk(rxq.size(), 10); chk(rxq[9], 64'h205);
    chk(sop_n, 2);
    chk(eop_n, 2);
    frame(3, 64'h300); chk(rxq.size(), 10);
    chk(sop_n, 2);
    wb(0, REG_STATUS, 0); chk(r[STAT_RX_OFF_BIT], 1);
    wb(1, REG_CTRL, 32'h09);
    $display("receive test done");
    @(posedge core_clk) err_cmd <= 20'h80001;
    cyc(3); err_cmd <= '0; cyc(40);
    chk(lane_sum[0], 3); chk(lane_sum[19], 3); chk(lane_sum[5], 0);
    wb(0, REG_IRQ_STATUS, 0); chk(r[IRQ_LANE_ERR_BIT], 1);
    chk(r[IRQ_TX_ERR_BIT], 1);
    $display("lane test done");
    @(posedge core_clk) rx_force_realign <= 1'b1;
    @(posedge core_clk) rx_force_realign <= 1'b0;
    cyc(5); chk(stat_tx_local_fault, 1);
    wb(0, REG_IRQ_STATUS, 0); chk(r[IRQ_REALIGN_BIT], 1);
    chk(r[IRQ_LF_SET_BIT], 1);
    wait_lf(0); chk(n >= 50, 1);
    $display("realign test done");
    end_sim();
  end
endmodule : tb_eth_path_control_status
